// >>> rtl/htw_regs.svh
// register offsets, field positions, reset values and timing counts
// for the host two-wire register slave; definitions only
`ifndef HTW_REGS_SVH
`define HTW_REGS_SVH

// register offsets in the 8-bit register space
`define HTW_REG_SCAN_CONTROL    8'h62
`define HTW_REG_GPP_CONTROL     8'h8C

// scan_control fields
`define HTW_SCAN_MASTER_BIT     3

// general_port_control fields
`define HTW_GPP_ENABLE_BIT      0
`define HTW_GPP_CLK_LVL_BIT     1
`define HTW_GPP_DATA_LVL_BIT    2
`define HTW_GPP_PIN0_SENSE_BIT  4
`define HTW_GPP_PIN1_SENSE_BIT  5

// reset values
`define HTW_REG_RESET           8'h00
`define HTW_PTR_CLEAR           8'h00

// fixed upper bits of the 7-bit slave address, above the five straps
`define HTW_ADDR_FIXED          2'h0

// core cycles after reset release before the straps are captured
`define HTW_STRAP_SETTLE        2'h2

`endif

// >>> rtl/htw_pkg.sv
// types shared by the host two-wire register slave
// assumes the constants header is included where numbers are needed
package htw_pkg;

  // link-side slave sequencer; gray codes along idle-addr-ack-rx path, ack to tx flips two bits
  typedef enum logic [2:0] {
    HTW_IDLE   = 3'b000,
    HTW_ADDR   = 3'b001,
    HTW_ACK    = 3'b011,
    HTW_RX     = 3'b010,
    HTW_TX     = 3'b110,
    HTW_TX_ACK = 3'b111,
    HTW_HOLD   = 3'b101
  } htw_link_state_e;

  typedef logic [7:0] htw_byte_t;

endpackage

// >>> rtl/htw_sync.sv
// two flip-flop synchroniser, any width, resets to zero
// assumes d is steady or changes in at most one bit per transfer
`timescale 1ns/100ps
module htw_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset of the receiving domain
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;   // first stage, read only by q
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  // next values: plain shift through two stages
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // registers; async clear takes constants only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule // htw_sync

// >>> rtl/htw_slave.sv
// host two-wire register slave: 256 x 8 register space behind a serial slave
// assumes link_clk free-runs fast enough to oversample the host bus pins
// and that pin levels are resolved from the enables outside this module
//
// Notes on behaviour
// - bytes shift most significant bit first
// - five strap pins form the slave address
// - straps captured at reset release, kept
// - address lsb one means device transmits
// - first written byte after stop or reset loads pointer only
// - pointer is eight bits, 256 locations
// - pointer advances after each data byte
// - stop after matched transfer clears pointer
// - mismatched address ignored until next start
// - start leaves pointer unchanged
// - write after repeated start continues pointer
// - read after stop begins at register zero
// - general port configurable as secondary bus
// - scan control bit three selects master
`include "htw_regs.svh"
`timescale 1ns/100ps
module htw_slave (
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // host bus sampling clock
  input  wire logic       link_clk,
  // address straps
  input  wire logic [4:0] address_strap_pins,
  // host bus, open drain data
  input  wire logic       host_serial_clock,
  input  wire logic       host_serial_data_in,
  output logic            host_serial_data_out,
  output logic            host_serial_data_oe_n,
  // general pins, open drain
  input  wire logic       general_pin_zero_in,
  output logic            general_pin_zero_out,
  output logic            general_pin_zero_oe_n,
  input  wire logic       general_pin_one_in,
  output logic            general_pin_one_out,
  output logic            general_pin_one_oe_n,
  // register values for the rest of the device
  output logic [7:0]      scan_control_value,
  output logic [7:0]      general_port_control_value
);
  // ---------------- core domain state ----------------
  htw_pkg::htw_byte_t regs_r   [0:255];  // register space
  htw_pkg::htw_byte_t regs_nxt [0:255];
  logic               req_d_r, req_d_nxt;           // last seen request toggle
  logic               ack_tog_r, ack_tog_nxt;       // answer toggle to the link
  htw_pkg::htw_byte_t rd_r, rd_nxt;                 // read data, steady while ack settles
  logic [1:0]         settle_r, settle_nxt;         // strap settle count
  logic [4:0]         slave_addr_r, slave_addr_nxt; // captured straps
  logic               addr_valid_r, addr_valid_nxt; // straps captured
  logic               gp0_oe_n_r, gp0_oe_n_nxt;
  logic               gp1_oe_n_r, gp1_oe_n_nxt;
  logic               gp_out_r, gp_out_nxt;
  // ---------------- link domain state ----------------
  htw_pkg::htw_link_state_e st_r, st_nxt;
  logic [2:0]         bit_r, bit_nxt;    // bit count in byte
  htw_pkg::htw_byte_t sh_r, sh_nxt;      // shift register
  htw_pkg::htw_byte_t ptr_r, ptr_nxt;    // subaddress_pointer
  logic               fresh_r, fresh_nxt;   // no match since last stop
  logic               match_r, match_nxt;   // addressed since last stop
  logic               rw_r, rw_nxt;         // direction of current transfer
  logic               needp_r, needp_nxt;   // next rx byte is the pointer
  logic               done_r, done_nxt;     // byte or ack sampled
  logic               rq_tog_r, rq_tog_nxt; // request toggle to core
  logic               rq_wr_r, rq_wr_nxt;
  htw_pkg::htw_byte_t rq_addr_r, rq_addr_nxt;
  htw_pkg::htw_byte_t rq_data_r, rq_data_nxt;
  htw_pkg::htw_byte_t rdat_r, rdat_nxt;      // last read answer
  logic               ackseen_r, ackseen_nxt;
  logic               scl_d_r, sda_d_r;     // previous synced levels
  logic               sda_oe_n_r, sda_oe_n_nxt;
  logic               sda_out_r, sda_out_nxt;
  // ---------------- synchronisers ----------------
  logic       link_rst_n, req_s; // link reset release; request toggle in core domain
  logic       ack_s, valid_s;    // answer toggle and strap capture done, link domain
  logic [4:0] strap_s;      // straps in core domain
  logic [1:0] gp_s;         // general pin levels in core domain
  logic [1:0] bus_s;        // {clock, data} in link domain
  // link reset: asserts at once, releases on link_clk
  htw_sync #(.WIDTH(1)) u_link_rst (.clk(link_clk), .rst_n(reset_n), .d(1'b1), .q(link_rst_n));
  htw_sync #(.WIDTH(1)) u_req (.clk(core_clk), .rst_n(reset_n), .d(rq_tog_r), .q(req_s));
  htw_sync #(.WIDTH(5)) u_strap (
    .clk(core_clk), .rst_n(reset_n), .d(address_strap_pins), .q(strap_s));
  htw_sync #(.WIDTH(2)) u_gp (
    .clk(core_clk), .rst_n(reset_n),
    .d({general_pin_one_in, general_pin_zero_in}), .q(gp_s));
  htw_sync #(.WIDTH(2)) u_bus (
    .clk(link_clk), .rst_n(link_rst_n),
    .d({host_serial_clock, host_serial_data_in}), .q(bus_s));
  htw_sync #(.WIDTH(1)) u_ack (.clk(link_clk), .rst_n(link_rst_n), .d(ack_tog_r), .q(ack_s));
  htw_sync #(.WIDTH(1)) u_valid (
    .clk(link_clk), .rst_n(link_rst_n), .d(addr_valid_r), .q(valid_s));
  // ---------------- core: strap capture ----------------
  // straps sampled once after release, so the sync stages hold real pins
  always_comb begin
    settle_nxt     = settle_r;
    slave_addr_nxt = slave_addr_r;
    addr_valid_nxt = addr_valid_r;
    if (!addr_valid_r) begin
      if (settle_r == `HTW_STRAP_SETTLE) begin
        slave_addr_nxt = strap_s;
        addr_valid_nxt = 1'b1;
      end else begin
        settle_nxt = settle_r + 2'h1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_r     <= 2'h0;
      slave_addr_r <= 5'h00;
      addr_valid_r <= 1'b0;
    end else begin
      settle_r     <= settle_nxt;
      slave_addr_r <= slave_addr_nxt;
      addr_valid_r <= addr_valid_nxt;
    end
  end
  // ---------------- core: register access ----------------
  // a toggle change means the link holds a steady request for us
  always_comb begin
    regs_nxt    = regs_r;
    req_d_nxt   = req_s;
    ack_tog_nxt = ack_tog_r;
    rd_nxt      = rd_r;
    if (req_s != req_d_r) begin
      ack_tog_nxt = ~ack_tog_r;
      if (rq_wr_r) begin
        regs_nxt[rq_addr_r] = rq_data_r;
      end else if (rq_addr_r == `HTW_REG_GPP_CONTROL) begin
        // live pin levels read back in the sense bits
        rd_nxt = regs_r[rq_addr_r];
        rd_nxt[`HTW_GPP_PIN0_SENSE_BIT] = gp_s[0];
        rd_nxt[`HTW_GPP_PIN1_SENSE_BIT] = gp_s[1];
      end else begin
        rd_nxt = regs_r[rq_addr_r];
      end
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 256; i++) begin
        regs_r[i] <= `HTW_REG_RESET;
      end
      req_d_r   <= 1'b0;
      ack_tog_r <= 1'b0;
      rd_r      <= 8'h00;
    end else begin
      regs_r    <= regs_nxt;
      req_d_r   <= req_d_nxt;
      ack_tog_r <= ack_tog_nxt;
      rd_r      <= rd_nxt;
    end
  end
  // ---------------- core: secondary bus pins ----------------
  // driven only in master mode with the port set up as a bus; software
  // sets the line levels, so timing on the tuner bus is up to it
  always_comb begin
    logic en;
    en = regs_r[`HTW_REG_GPP_CONTROL][`HTW_GPP_ENABLE_BIT]
       & regs_r[`HTW_REG_SCAN_CONTROL][`HTW_SCAN_MASTER_BIT];
    gp0_oe_n_nxt = ~(en & ~regs_r[`HTW_REG_GPP_CONTROL][`HTW_GPP_CLK_LVL_BIT]);
    gp1_oe_n_nxt = ~(en & ~regs_r[`HTW_REG_GPP_CONTROL][`HTW_GPP_DATA_LVL_BIT]);
    gp_out_nxt   = 1'b0;   // open drain: only ever pulls low
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gp0_oe_n_r <= 1'b1;
      gp1_oe_n_r <= 1'b1;
      gp_out_r   <= 1'b0;
    end else begin
      gp0_oe_n_r <= gp0_oe_n_nxt;
      gp1_oe_n_r <= gp1_oe_n_nxt;
      gp_out_r   <= gp_out_nxt;
    end
  end
  // ---------------- link: slave sequencer ----------------
  // stop and start win over any state; data changes follow clock falls
  always_comb begin
    logic scl_rise, scl_fall, start_c, stop_c;
    scl_rise = bus_s[1] & ~scl_d_r;
    scl_fall = ~bus_s[1] & scl_d_r;
    start_c  = bus_s[1] & scl_d_r & sda_d_r & ~bus_s[0];
    stop_c   = bus_s[1] & scl_d_r & ~sda_d_r & bus_s[0];
    st_nxt = st_r;       bit_nxt = bit_r;     sh_nxt = sh_r;
    ptr_nxt = ptr_r;     fresh_nxt = fresh_r; match_nxt = match_r;
    rw_nxt = rw_r;       needp_nxt = needp_r; done_nxt = done_r;
    rq_tog_nxt = rq_tog_r; rq_wr_nxt = rq_wr_r;
    rq_addr_nxt = rq_addr_r; rq_data_nxt = rq_data_r;
    rdat_nxt = rdat_r;   ackseen_nxt = ack_s;
    if (ack_s != ackseen_r) rdat_nxt = rd_r;   // steady: core set it in the same cycle as the toggle
    if (stop_c) begin
      st_nxt    = htw_pkg::HTW_IDLE;
      fresh_nxt = 1'b1;
      match_nxt = 1'b0;
      if (match_r) ptr_nxt = `HTW_PTR_CLEAR;
    end else if (start_c) begin
      st_nxt   = htw_pkg::HTW_ADDR;
      bit_nxt  = 3'h0;
      done_nxt = 1'b0;
    end else begin
      case (st_r)
        htw_pkg::HTW_ADDR: begin
          if (scl_rise) begin
            sh_nxt   = {sh_r[6:0], bus_s[0]};
            bit_nxt  = bit_r + 3'h1;
            done_nxt = (bit_r == 3'h7);
          end else if (scl_fall && done_r) begin
            done_nxt = 1'b0;
            if (valid_s && sh_r[7:1] == {`HTW_ADDR_FIXED, slave_addr_r}) begin
              st_nxt    = htw_pkg::HTW_ACK;
              match_nxt = 1'b1;
              rw_nxt    = sh_r[0];
              needp_nxt = fresh_r & ~sh_r[0];
              fresh_nxt = 1'b0;
              if (sh_r[0]) begin
                rq_tog_nxt  = ~rq_tog_r;                 // prefetch first byte
                rq_wr_nxt   = 1'b0;
                rq_addr_nxt = ptr_r;
              end
            end else begin
              st_nxt = htw_pkg::HTW_IDLE;
            end
          end
        end
        htw_pkg::HTW_ACK: begin
          if (scl_fall) begin
            bit_nxt = 3'h0;
            if (rw_r) begin
              st_nxt = htw_pkg::HTW_TX;
              sh_nxt = rdat_nxt;
            end else begin
              st_nxt = htw_pkg::HTW_RX;
            end
          end
        end
        htw_pkg::HTW_RX: begin
          if (scl_rise) begin
            sh_nxt   = {sh_r[6:0], bus_s[0]};
            bit_nxt  = bit_r + 3'h1;
            done_nxt = (bit_r == 3'h7);
          end else if (scl_fall && done_r) begin
            done_nxt = 1'b0;
            st_nxt   = htw_pkg::HTW_ACK;
            if (needp_r) begin
              ptr_nxt   = sh_r;
              needp_nxt = 1'b0;
            end else begin
              rq_tog_nxt  = ~rq_tog_r;
              rq_wr_nxt   = 1'b1;
              rq_addr_nxt = ptr_r;
              rq_data_nxt = sh_r;
              ptr_nxt     = ptr_r + 8'h01;
            end
          end
        end
        htw_pkg::HTW_TX: begin
          if (scl_fall) begin
            sh_nxt  = {sh_r[6:0], 1'b0};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              st_nxt      = htw_pkg::HTW_TX_ACK;
              ptr_nxt     = ptr_r + 8'h01;
              rq_tog_nxt  = ~rq_tog_r;                   // prefetch next byte
              rq_wr_nxt   = 1'b0;
              rq_addr_nxt = ptr_r + 8'h01;
            end
          end
        end
        htw_pkg::HTW_TX_ACK: begin
          if (scl_rise) begin
            if (bus_s[0]) begin
              st_nxt = htw_pkg::HTW_HOLD;
            end else begin
              done_nxt = 1'b1;
            end
          end else if (scl_fall && done_r) begin
            done_nxt = 1'b0;
            st_nxt   = htw_pkg::HTW_TX;
            bit_nxt  = 3'h0;
            sh_nxt   = rdat_nxt;
          end
        end
        htw_pkg::HTW_IDLE, htw_pkg::HTW_HOLD: begin
          // bus released; only start or stop moves on
        end
        default: begin
          st_nxt = htw_pkg::HTW_IDLE;
        end
      endcase
    end
    // data pin from next state, so it lands one link cycle after the fall
    if (st_nxt == htw_pkg::HTW_ACK) begin
      sda_oe_n_nxt = 1'b0;
    end else if (st_nxt == htw_pkg::HTW_TX) begin
      sda_oe_n_nxt = sh_nxt[7];
    end else begin
      sda_oe_n_nxt = 1'b1;
    end
    sda_out_nxt = 1'b0;
  end
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_r <= htw_pkg::HTW_IDLE; bit_r <= 3'h0;    sh_r <= 8'h00;
      ptr_r <= `HTW_PTR_CLEAR;   fresh_r <= 1'b1;  match_r <= 1'b0;
      rw_r <= 1'b0;    needp_r <= 1'b0;   done_r <= 1'b0;
      rq_tog_r <= 1'b0; rq_wr_r <= 1'b0;  rq_addr_r <= 8'h00;
      rq_data_r <= 8'h00; rdat_r <= 8'h00; ackseen_r <= 1'b0;
      scl_d_r <= 1'b1;  sda_d_r <= 1'b1;
      sda_oe_n_r <= 1'b1; sda_out_r <= 1'b0;
    end else begin
      st_r <= st_nxt;   bit_r <= bit_nxt;  sh_r <= sh_nxt;
      ptr_r <= ptr_nxt; fresh_r <= fresh_nxt; match_r <= match_nxt;
      rw_r <= rw_nxt;   needp_r <= needp_nxt; done_r <= done_nxt;
      rq_tog_r <= rq_tog_nxt; rq_wr_r <= rq_wr_nxt; rq_addr_r <= rq_addr_nxt;
      rq_data_r <= rq_data_nxt; rdat_r <= rdat_nxt; ackseen_r <= ackseen_nxt;
      scl_d_r <= bus_s[1]; sda_d_r <= bus_s[0];
      sda_oe_n_r <= sda_oe_n_nxt; sda_out_r <= sda_out_nxt;
    end
  end
  // ---------------- outputs, all from flops ----------------
  assign host_serial_data_out       = sda_out_r;
  assign host_serial_data_oe_n      = sda_oe_n_r;
  assign general_pin_zero_out       = gp_out_r;
  assign general_pin_zero_oe_n      = gp0_oe_n_r;
  assign general_pin_one_out        = gp_out_r;
  assign general_pin_one_oe_n       = gp1_oe_n_r;
  assign scan_control_value         = regs_r[`HTW_REG_SCAN_CONTROL];
  assign general_port_control_value = regs_r[`HTW_REG_GPP_CONTROL];
endmodule // htw_slave

// >>> verification/htw_slave_assertions.sv
// concurrent checks on the host two-wire register slave, ports only
// assumes it is bound onto htw_slave and that pin levels are resolved outside
`include "htw_regs.svh"
`timescale 1ns/100ps
module htw_slave_assertions (
  // clocks and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       link_clk,
  // straps and host bus
  input wire logic [4:0] address_strap_pins,
  input wire logic       host_serial_clock,
  input wire logic       host_serial_data_in,
  input wire logic       host_serial_data_out,
  input wire logic       host_serial_data_oe_n,
  // general pins
  input wire logic       general_pin_zero_in,
  input wire logic       general_pin_zero_out,
  input wire logic       general_pin_zero_oe_n,
  input wire logic       general_pin_one_in,
  input wire logic       general_pin_one_out,
  input wire logic       general_pin_one_oe_n,
  // register values
  input wire logic [7:0] scan_control_value,
  input wire logic [7:0] general_port_control_value
);
  // tuner pin pulls wanted by the two registers
  wire logic want_clk_pull = general_port_control_value[`HTW_GPP_ENABLE_BIT]
                           & scan_control_value[`HTW_SCAN_MASTER_BIT]
                           & ~general_port_control_value[`HTW_GPP_CLK_LVL_BIT];
  wire logic want_dat_pull = general_port_control_value[`HTW_GPP_ENABLE_BIT]
                           & scan_control_value[`HTW_SCAN_MASTER_BIT]
                           & ~general_port_control_value[`HTW_GPP_DATA_LVL_BIT];

  // registers steady for three samples, so the pin flops have caught up
  sequence s_regs_held;
    scan_control_value == $past(scan_control_value) &&
    scan_control_value == $past(scan_control_value, 2) &&
    general_port_control_value == $past(general_port_control_value) &&
    general_port_control_value == $past(general_port_control_value, 2);
  endsequence
  // first sample after reset release
  sequence s_released;
    $rose(reset_n);
  endsequence

  a_pin0_pull: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_regs_held |-> general_pin_zero_oe_n == !want_clk_pull)
    else $error("tuner clock pin pull does not follow registers");
  a_pin1_pull: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_regs_held |-> general_pin_one_oe_n == !want_dat_pull)
    else $error("tuner data pin pull does not follow registers");
  a_outs_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    !host_serial_data_out && !general_pin_zero_out && !general_pin_one_out)
    else $error("open drain output driven high");
  a_data_on_low: assert property (@(posedge link_clk) disable iff (!reset_n)
    !$stable(host_serial_data_oe_n) |-> !host_serial_clock)
    else $error("host data changed while host clock high");
  a_pull_lasts: assert property (@(posedge link_clk) disable iff (!reset_n)
    $fell(host_serial_data_oe_n) |-> (!host_serial_data_oe_n) [*8])
    else $error("host data pull shorter than a clock half");
  a_bus_quiet: assert property (@(posedge link_clk) disable iff (!reset_n)
    s_released |-> host_serial_data_oe_n [*8])
    else $error("host data pulled right after reset");
  a_reset_vals: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_released |-> scan_control_value == `HTW_REG_RESET
                && general_port_control_value == `HTW_REG_RESET)
    else $error("register values not cleared by reset");
  a_pins_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_released |-> (general_pin_zero_oe_n && general_pin_one_oe_n) [*4])
    else $error("tuner pins pulled after reset");
endmodule // htw_slave_assertions

bind htw_slave htw_slave_assertions u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
  .address_strap_pins(address_strap_pins), .host_serial_clock(host_serial_clock),
  .host_serial_data_in(host_serial_data_in), .host_serial_data_out(host_serial_data_out),
  .host_serial_data_oe_n(host_serial_data_oe_n), .general_pin_zero_in(general_pin_zero_in),
  .general_pin_zero_out(general_pin_zero_out), .general_pin_zero_oe_n(general_pin_zero_oe_n),
  .general_pin_one_in(general_pin_one_in), .general_pin_one_out(general_pin_one_out),
  .general_pin_one_oe_n(general_pin_one_oe_n), .scan_control_value(scan_control_value),
  .general_port_control_value(general_port_control_value)
);

// >>> verification/htw_host_model.sv
// host bus master model: start, stop, byte write and byte read
// assumes a pull-up on data outside; paced on falling core clock edges
`timescale 1ns/100ps
module htw_host_model (
  // pacing clock
  input wire logic core_clk,
  // host bus: clock driven, data pulled low only
  output logic     scl,
  output logic     sda_pull,
  input wire logic sda
);
  localparam int T_LOW  = 60; // plus 8 lead cycles, keeps rate under 400 kHz
  localparam int T_HIGH = 60;
  logic [7:0] got_byte;       // last byte read from the device
  event       got_ev;         // fires when got_byte is fresh

  // idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    got_byte = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one clock: data changes a little after clock fall, so no false start
  task automatic bit_io(input logic b, output logic r);
    wt(8);
    sda_pull = ~b;
    wt(T_LOW);
    scl = 1'b1;
    wt(T_HIGH / 2);
    r = sda;
    wt(T_HIGH / 2);
    scl = 1'b0;
  endtask
  // start or repeated start, leaves clock low
  task automatic start();
    wt(8);
    sda_pull = 1'b0;
    wt(T_LOW);
    scl = 1'b1;
    wt(T_HIGH);
    sda_pull = 1'b1;
    wt(T_HIGH);
    scl = 1'b0;
  endtask
  // stop, bus left released
  task automatic stop();
    wt(8);
    sda_pull = 1'b1;
    wt(T_LOW);
    scl = 1'b1;
    wt(T_HIGH);
    sda_pull = 1'b0;
    wt(T_HIGH);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
    got_byte = d;
    -> got_ev;
  endtask
endmodule // htw_host_model

// >>> verification/tb.sv
// self-checking bench for the host two-wire register slave
// assumes pull-ups on host data and both tuner pins
`include "htw_regs.svh"
`timescale 1ns/100ps
module tb;
  logic       core_clk, link_clk, reset_n; // clocks and reset
  logic [4:0] strap, own;                  // strap pins, captured address
  logic       scl, host_pull;              // host model outputs
  logic       sda_oe_n, sda_o, g0_oe_n, g0_o, g1_oe_n, g1_o;
  logic [7:0] scan_v, gpc_v;               // register values
  logic [7:0] q[$];                        // expected read bytes
  logic [7:0] d[3];                        // random data
  int         n_fail, samples_checked, cycles, seed;
  // resolved wires, pull-ups where nobody pulls
  wire logic sda = (sda_oe_n | sda_o) & ~host_pull;
  wire logic g0  = g0_oe_n | g0_o;
  wire logic g1  = g1_oe_n | g1_o;

  htw_slave uut (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
    .address_strap_pins(strap), .host_serial_clock(scl), .host_serial_data_in(sda),
    .host_serial_data_out(sda_o), .host_serial_data_oe_n(sda_oe_n),
    .general_pin_zero_in(g0), .general_pin_zero_out(g0_o), .general_pin_zero_oe_n(g0_oe_n),
    .general_pin_one_in(g1), .general_pin_one_out(g1_o), .general_pin_one_oe_n(g1_oe_n),
    .scan_control_value(scan_v), .general_port_control_value(gpc_v));
  htw_host_model host (.core_clk(core_clk), .scl(scl), .sda_pull(host_pull), .sda(sda));

  // clocks, link clock offset so the phases drift apart
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // start plus address byte, acknowledge compared
  task automatic sa(input logic rw, input logic [4:0] a5, input logic e);
    logic a;
    host.start();
    host.wr_byte({`HTW_ADDR_FIXED, a5, rw}, a);
    check({7'h00, a}, {7'h00, e});
  endtask
  task automatic wb(input logic [7:0] v, input logic e);
    logic a;
    host.wr_byte(v, a);
    check({7'h00, a}, {7'h00, e});
  endtask
  // expected byte noted before the read is driven
  task automatic rb(input logic [7:0] exp, input logic nack);
    q.push_back(exp);
    host.rd_byte(nack);
  endtask
  // monitor: every read byte meets the oldest note
  initial forever begin
    @(host.got_ev);
    check(host.got_byte, q.pop_front());
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      close_out();
    end
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    seed = 32'h71a24525;
    reset_n = 1'b0;
    own = 5'($random(seed));
    strap = own;
    for (int i = 0; i < 3; i++) d[i] = 8'($random(seed));
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (20) @(negedge core_clk);
    strap = own ^ 5'h0B; // late strap change must not move the address
    repeat (40) @(negedge core_clk);
    check(scan_v, `HTW_REG_RESET);
    check(gpc_v, `HTW_REG_RESET);
    check({5'h00, sda_oe_n, g0_oe_n, g1_oe_n}, 8'h07);
    $display("test reset done");
    // burst write from zero, then read after stop starts at zero
    sa(1'b0, own, 1'b0);
    wb(8'h00, 1'b0);
    for (int i = 0; i < 3; i++) wb(d[i], 1'b0);
    host.stop();
    sa(1'b1, own, 1'b0);
    rb(d[0], 1'b0);
    rb(d[1], 1'b0);
    rb(d[2], 1'b1);
    host.stop();
    $display("test burst done");
    // combined messages across repeated starts
    sa(1'b0, own, 1'b0);
    wb(`HTW_REG_SCAN_CONTROL, 1'b0);
    wb(8'h08, 1'b0);
    wb(d[0], 1'b0);
    host.stop();
    check(scan_v, 8'h08);
    sa(1'b0, own, 1'b0);
    wb(`HTW_REG_SCAN_CONTROL, 1'b0);
    sa(1'b1, own, 1'b0);
    rb(8'h08, 1'b0);
    rb(d[0], 1'b1);
    sa(1'b0, own, 1'b0);
    wb(d[1], 1'b0);
    host.stop();
    sa(1'b0, own, 1'b0);
    wb(8'h64, 1'b0);
    sa(1'b1, own, 1'b0);
    rb(d[1], 1'b1);
    host.stop();
    check(scan_v, 8'h08);
    $display("test combined done");
    // foreign address: no acknowledge, nothing stored
    sa(1'b0, own ^ 5'h0B, 1'b1);
    wb(`HTW_REG_SCAN_CONTROL, 1'b1);
    wb(8'h00, 1'b1);
    host.stop();
    check(scan_v, 8'h08);
    $display("test foreign done");
    // secondary bus on the general pins
    sa(1'b0, own, 1'b0);
    wb(`HTW_REG_GPP_CONTROL, 1'b0);
    wb(8'h01, 1'b0);
    host.stop();
    check({6'h00, g0_oe_n, g1_oe_n}, 8'h00);
    sa(1'b0, own, 1'b0);
    wb(`HTW_REG_GPP_CONTROL, 1'b0);
    wb(8'h03, 1'b0);
    host.stop();
    check({6'h00, g0_oe_n, g1_oe_n}, 8'h02);
    sa(1'b0, own, 1'b0);
    wb(`HTW_REG_GPP_CONTROL, 1'b0);
    sa(1'b1, own, 1'b0);
    rb(8'h13, 1'b1);
    host.stop();
    sa(1'b0, own, 1'b0);
    wb(`HTW_REG_SCAN_CONTROL, 1'b0);
    wb(8'h00, 1'b0);
    host.stop();
    check({6'h00, g0_oe_n, g1_oe_n}, 8'h03);
    check(gpc_v, 8'h03);
    $display("test tuner done");
    // pointer wraps from the top location to zero
    sa(1'b0, own, 1'b0);
    wb(8'hFF, 1'b0);
    wb(d[2], 1'b0);
    wb(d[0], 1'b0);
    host.stop();
    sa(1'b0, own, 1'b0);
    wb(8'hFF, 1'b0);
    sa(1'b1, own, 1'b0);
    rb(d[2], 1'b0);
    rb(d[0], 1'b1);
    host.stop();
    $display("test wrap done");
    close_out();
  end
endmodule // tb
